/* src/pmgp_pkg.sv */
// multiplexed gpio ports: register map, pin masks and field positions
package pmgp_pkg;
   // ----------------------------------------------------------------
   // register addresses
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_QUAD_PU = 8'hA0;
   localparam logic [7:0] ADR_QUAD_OD = 8'hA1;
   localparam logic [7:0] ADR_SIX_OD = 8'hA2;
   localparam logic [7:0] ADR_SEVEN_OD = 8'hA4;
   localparam logic [7:0] ADR_SINGLE_PU = 8'hA6;
   localparam logic [7:0] ADR_SIX_PU = 8'hA7;
   localparam logic [7:0] ADR_SINGLE_OD = 8'hA8;
   localparam logic [7:0] ADR_SEVEN_PU = 8'hA9;
   localparam logic [7:0] ADR_QUAD_ALT = 8'hAA;
   localparam logic [7:0] ADR_SECOND_ALT = 8'hAB;
   localparam logic [7:0] ADR_CTRL = 8'hB2;
   localparam logic [7:0] ADR_QUAD_DATA = 8'hC0;
   localparam logic [7:0] ADR_QUAD_DIR = 8'hC1;
   localparam logic [7:0] ADR_SINGLE_DATA = 8'hC2;
   localparam logic [7:0] ADR_SINGLE_DIR = 8'hC3;
   localparam logic [7:0] ADR_SIX_DATA = 8'hC4;
   localparam logic [7:0] ADR_SIX_DIR = 8'hC5;
   localparam logic [7:0] ADR_SEVEN_DATA = 8'hC8;
   localparam logic [7:0] ADR_SEVEN_DIR = 8'hC9;
   // ----------------------------------------------------------------
   // implemented pins, reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] QUAD_MASK = 8'hD2;
   localparam logic [7:0] QUAD_ALT_OUT_MASK = 8'h10;
   localparam logic [7:0] SEVEN_MASK = 8'hFE;
   localparam logic [7:0] SEVEN_DRV_MASK = 8'h7E;
   localparam logic [7:0] SEVEN_MAIN_OSC = 8'h0C;
   localparam logic [7:0] SEVEN_SUB_OSC = 8'h60;
   localparam logic [7:0] SEVEN_RST_PIN = 8'h80;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int QUAD_EVT_BIT = 1;
   localparam int QUAD_BUZ_BIT = 4;
   localparam int QUAD_IRQ0_BIT = 6;
   localparam int QUAD_IRQ1_BIT = 7;
   localparam int PWM_SEL_BIT = 0;
   localparam int IRQ2_SEL_BIT = 1;
   localparam int IRQ3_SEL_BIT = 2;
   localparam int SEVEN_IRQ2_BIT = 1;
   localparam int SEVEN_IRQ3_BIT = 4;
   localparam int SEVEN_RST_BIT = 7;
   localparam int SUBCLK_DIS_BIT = 7;
endpackage

/* src/pmgp_port_if.sv */
// control and pin drive bundle between the top and one port driver
`timescale 1ns/1ns
interface pmgp_port_if #(parameter int W = 8);
   logic [W-1:0] data;
   logic [W-1:0] dir;
   logic [W-1:0] pu;
   logic [W-1:0] od;
   logic [W-1:0] alt;
   logic [W-1:0] alt_val;
   logic [W-1:0] hold;
   logic [W-1:0] pin_o;
   logic [W-1:0] pin_oe;
   logic [W-1:0] pin_pu;
   modport core (input data, dir, pu, od, alt, alt_val, hold,
      output pin_o, pin_oe, pin_pu);
   modport ctrl (output data, dir, pu, od, alt, alt_val, hold,
      input pin_o, pin_oe, pin_pu);
endinterface

/* src/pmgp_sync.sv */
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module pmgp_sync #(parameter int W = 8) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta <= '0;
         q <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

/* src/pmgp_port.sv */
// one port's pin driver: direction, open drain, pull-up, alternate out
`timescale 1ns/1ns
module pmgp_port (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   pmgp_port_if.core p
);
   logic [$bits(p.data)-1:0] val;
   logic [$bits(p.data)-1:0] drv;
   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // alternate output wins over data; held pins are lent to osc/reset
   assign val = (p.alt & p.alt_val) | (~p.alt & p.data);
   assign drv = (p.dir | p.alt) & ~p.hold;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         p.pin_o <= '0;
         p.pin_oe <= '0;
         p.pin_pu <= '0;
      end else if (ce) begin
         // open drain only pulls low, a high is left to the pull-up
         p.pin_oe <= drv & ~(p.od & val);
         p.pin_o <= val & ~p.od;
         p.pin_pu <= p.pu & ~p.hold;
      end
   end
   input_dir_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && ((~p.dir & ~p.alt) != '0)
      |=> (p.pin_oe & $past(~p.dir & ~p.alt)) == '0)
      else $error("input pin driven");
   open_drain_a: assert property (@(posedge clk) disable iff (!rstn)
      ce |=> (p.pin_o & $past(p.od)) == '0
      && (p.pin_oe & $past(p.od & val)) == '0)
      else $error("open drain pin driven high");
   pullup_sel_a: assert property (@(posedge clk) disable iff (!rstn)
      ce && ((p.pu & ~p.hold) != '0)
      |=> (p.pin_pu & $past(p.pu & ~p.hold)) != '0)
      else $error("pull-up not applied");
endmodule

/* src/pmgp_top.sv */
// multiplexed gpio ports: registers, read path and pin routing
`timescale 1ns/1ns
module pmgp_top
   import pmgp_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD_REG,
   input wire logic RD_PIN,
   output logic [7:0] RDATA,
   input wire logic [7:0] QUAD_PIN_I,
   output logic [7:0] QUAD_PIN_O,
   output logic [7:0] QUAD_PIN_OE,
   output logic [7:0] QUAD_PIN_PU,
   input wire logic SINGLE_PIN_I,
   output logic SINGLE_PIN_O,
   output logic SINGLE_PIN_OE,
   output logic SINGLE_PIN_PU,
   input wire logic [5:0] SIX_PIN_I,
   output logic [5:0] SIX_PIN_O,
   output logic [5:0] SIX_PIN_OE,
   output logic [5:0] SIX_PIN_PU,
   input wire logic [7:0] SEVEN_PIN_I,
   output logic [7:0] SEVEN_PIN_O,
   output logic [7:0] SEVEN_PIN_OE,
   output logic [7:0] SEVEN_PIN_PU,
   input wire logic MAIN_OSC_IO_OPT,
   input wire logic RESET_PIN_IO_OPT,
   input wire logic BUZZER_WAVE,
   input wire logic PWM_TIMER_WAVE,
   output logic TIMER0_EVENT,
   output logic [3:0] EXT_IRQ,
   output logic RESET_PIN_LEVEL,
   output logic SUBCLK_DISABLE
);
   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   logic [7:0] quad_data;
   logic [7:0] quad_dir;
   logic [7:0] quad_pu;
   logic [7:0] quad_od;
   logic [7:0] quad_alt;
   logic single_data;
   logic single_dir;
   logic single_pu;
   logic single_od;
   logic [5:0] six_data;
   logic [5:0] six_dir;
   logic [5:0] six_pu;
   logic [5:0] six_od;
   logic [7:0] seven_data;
   logic [7:0] seven_dir;
   logic [7:0] seven_pu;
   logic [7:0] seven_od;
   logic [7:0] second_alt;
   logic [7:0] ctrl;
   logic [7:0] next_rdata;
   logic [7:0] seven_hold;
   logic [7:0] quad_in;
   logic single_in;
   logic [5:0] six_in;
   logic [7:0] seven_in;
   logic wr;

   pmgp_port_if #(.W(8)) qp ();
   pmgp_port_if #(.W(1)) sp ();
   pmgp_port_if #(.W(6)) xp ();
   pmgp_port_if #(.W(8)) vp ();

   // every register is written as one whole byte
   assign wr = CE & WR;

   // ----------------------------------------------------------------
   // quad port registers
   // ----------------------------------------------------------------
   // unimplemented bits are masked off so they never drive a pin
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         quad_data <= REG_RESET;
         quad_dir <= REG_RESET;
         quad_pu <= REG_RESET;
         quad_od <= REG_RESET;
         quad_alt <= REG_RESET;
      end else if (wr) begin
         case (ADDR)
            ADR_QUAD_DATA: quad_data <= WDATA & QUAD_MASK;
            ADR_QUAD_DIR: quad_dir <= WDATA & QUAD_MASK;
            ADR_QUAD_PU: quad_pu <= WDATA & QUAD_MASK;
            ADR_QUAD_OD: quad_od <= WDATA & QUAD_MASK;
            ADR_QUAD_ALT: quad_alt <= WDATA & QUAD_MASK;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // single port registers
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         single_data <= 1'h0;
         single_dir <= 1'h0;
         single_pu <= 1'h0;
         single_od <= 1'h0;
      end else if (wr) begin
         case (ADDR)
            ADR_SINGLE_DATA: single_data <= WDATA[0];
            ADR_SINGLE_DIR: single_dir <= WDATA[0];
            ADR_SINGLE_PU: single_pu <= WDATA[0];
            ADR_SINGLE_OD: single_od <= WDATA[0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // six-bit port registers
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         six_data <= REG_RESET[5:0];
         six_dir <= REG_RESET[5:0];
         six_pu <= REG_RESET[5:0];
         six_od <= REG_RESET[5:0];
      end else if (wr) begin
         case (ADDR)
            ADR_SIX_DATA: six_data <= WDATA[5:0];
            ADR_SIX_DIR: six_dir <= WDATA[5:0];
            ADR_SIX_PU: six_pu <= WDATA[5:0];
            ADR_SIX_OD: six_od <= WDATA[5:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // seven-bit port registers
   // ----------------------------------------------------------------
   // bit 7 is input only, so it has pull-up but no drive control
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         seven_data <= REG_RESET;
         seven_dir <= REG_RESET;
         seven_pu <= REG_RESET;
         seven_od <= REG_RESET;
      end else if (wr) begin
         case (ADDR)
            ADR_SEVEN_DATA: seven_data <= WDATA & SEVEN_DRV_MASK;
            ADR_SEVEN_DIR: seven_dir <= WDATA & SEVEN_DRV_MASK;
            ADR_SEVEN_PU: seven_pu <= WDATA & SEVEN_MASK;
            ADR_SEVEN_OD: seven_od <= WDATA & SEVEN_DRV_MASK;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // selection and control registers
   // ----------------------------------------------------------------
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         second_alt <= REG_RESET;
         ctrl <= REG_RESET;
      end else if (wr) begin
         case (ADDR)
            ADR_SECOND_ALT: second_alt <= WDATA;
            ADR_CTRL: ctrl <= WDATA;
            default: ;
         endcase
      end
   end

   assign SUBCLK_DISABLE = ctrl[SUBCLK_DIS_BIT];

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   pmgp_sync #(.W(8)) quad_sync (.clk(SYS_CLK), .rstn(RSTN), .ce(CE),
      .d(QUAD_PIN_I), .q(quad_in));
   pmgp_sync #(.W(1)) single_sync (.clk(SYS_CLK), .rstn(RSTN), .ce(CE),
      .d(SINGLE_PIN_I), .q(single_in));
   pmgp_sync #(.W(6)) six_sync (.clk(SYS_CLK), .rstn(RSTN), .ce(CE),
      .d(SIX_PIN_I), .q(six_in));
   pmgp_sync #(.W(8)) seven_sync (.clk(SYS_CLK), .rstn(RSTN), .ce(CE),
      .d(SEVEN_PIN_I), .q(seven_in));

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   // write-only registers and unmapped addresses read as zero, so a
   // read-modify-write on them would silently clear them
   always_comb begin
      next_rdata = REG_RESET;
      if (RD_PIN) begin
         case (ADDR)
            ADR_QUAD_DATA: next_rdata = quad_in & QUAD_MASK;
            ADR_SINGLE_DATA: next_rdata = {7'h00, single_in};
            ADR_SIX_DATA: next_rdata = {2'h0, six_in};
            ADR_SEVEN_DATA: next_rdata = seven_in & SEVEN_MASK;
            default: next_rdata = REG_RESET;
         endcase
      end else if (RD_REG) begin
         case (ADDR)
            ADR_QUAD_DATA: next_rdata = quad_data;
            ADR_SINGLE_DATA: next_rdata = {7'h00, single_data};
            ADR_SIX_DATA: next_rdata = {2'h0, six_data};
            ADR_SEVEN_DATA: next_rdata = seven_data;
            ADR_CTRL: next_rdata = ctrl;
            default: next_rdata = REG_RESET;
         endcase
      end
   end

   // read data holds until the next read strobe
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         RDATA <= REG_RESET;
      end else if (CE && (RD_REG || RD_PIN)) begin
         RDATA <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // peripheral inputs
   // ----------------------------------------------------------------
   // direction is ignored so a peripheral sees its pin even as output
   always_ff @(posedge SYS_CLK) begin
      if (!RSTN) begin
         TIMER0_EVENT <= 1'h0;
         EXT_IRQ <= 4'h0;
         RESET_PIN_LEVEL <= 1'h0;
      end else if (CE) begin
         TIMER0_EVENT <= quad_alt[QUAD_EVT_BIT] & quad_in[QUAD_EVT_BIT];
         EXT_IRQ[0] <= quad_alt[QUAD_IRQ0_BIT] & quad_in[QUAD_IRQ0_BIT];
         EXT_IRQ[1] <= quad_alt[QUAD_IRQ1_BIT] & quad_in[QUAD_IRQ1_BIT];
         EXT_IRQ[2] <= second_alt[IRQ2_SEL_BIT]
            & seven_in[SEVEN_IRQ2_BIT];
         EXT_IRQ[3] <= second_alt[IRQ3_SEL_BIT]
            & seven_in[SEVEN_IRQ3_BIT];
         RESET_PIN_LEVEL <= seven_in[SEVEN_RST_BIT];
      end
   end

   // ----------------------------------------------------------------
   // pins lent to the oscillators and the reset input
   // ----------------------------------------------------------------
   // the flash options are static levels from the same clock domain
   always_comb begin
      seven_hold = REG_RESET;
      if (!MAIN_OSC_IO_OPT) begin
         seven_hold = seven_hold | SEVEN_MAIN_OSC;
      end
      if (!ctrl[SUBCLK_DIS_BIT]) begin
         seven_hold = seven_hold | SEVEN_SUB_OSC;
      end
      if (!RESET_PIN_IO_OPT) begin
         seven_hold = seven_hold | SEVEN_RST_PIN;
      end
   end

   // ----------------------------------------------------------------
   // port drivers
   // ----------------------------------------------------------------
   assign qp.data = quad_data;
   assign qp.dir = quad_dir;
   assign qp.pu = quad_pu;
   assign qp.od = quad_od;
   assign qp.alt = quad_alt & QUAD_ALT_OUT_MASK;
   assign qp.alt_val = BUZZER_WAVE ? QUAD_ALT_OUT_MASK : REG_RESET;
   assign qp.hold = REG_RESET;
   assign sp.data = single_data;
   assign sp.dir = single_dir;
   assign sp.pu = single_pu;
   assign sp.od = single_od;
   assign sp.alt = second_alt[PWM_SEL_BIT];
   assign sp.alt_val = PWM_TIMER_WAVE;
   assign sp.hold = 1'h0;
   assign xp.data = six_data;
   assign xp.dir = six_dir;
   assign xp.pu = six_pu;
   assign xp.od = six_od;
   assign xp.alt = REG_RESET[5:0];
   assign xp.alt_val = REG_RESET[5:0];
   assign xp.hold = REG_RESET[5:0];
   assign vp.data = seven_data;
   assign vp.dir = seven_dir;
   assign vp.pu = seven_pu;
   assign vp.od = seven_od;
   assign vp.alt = REG_RESET;
   assign vp.alt_val = REG_RESET;
   assign vp.hold = seven_hold;

   pmgp_port quad_drv (.clk(SYS_CLK), .rstn(RSTN), .ce(CE), .p(qp));
   pmgp_port single_drv (.clk(SYS_CLK), .rstn(RSTN), .ce(CE), .p(sp));
   pmgp_port six_drv (.clk(SYS_CLK), .rstn(RSTN), .ce(CE), .p(xp));
   pmgp_port seven_drv (.clk(SYS_CLK), .rstn(RSTN), .ce(CE), .p(vp));

   assign QUAD_PIN_O = qp.pin_o;
   assign QUAD_PIN_OE = qp.pin_oe;
   assign QUAD_PIN_PU = qp.pin_pu;
   assign SINGLE_PIN_O = sp.pin_o;
   assign SINGLE_PIN_OE = sp.pin_oe;
   assign SINGLE_PIN_PU = sp.pin_pu;
   assign SIX_PIN_O = xp.pin_o;
   assign SIX_PIN_OE = xp.pin_oe;
   assign SIX_PIN_PU = xp.pin_pu;
   assign SEVEN_PIN_O = vp.pin_o;
   assign SEVEN_PIN_OE = vp.pin_oe;
   assign SEVEN_PIN_PU = vp.pin_pu;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking dc @(posedge SYS_CLK);
   endclocking
   default disable iff (!RSTN);

   sequence pin_read_s;
      CE && RD_PIN && ADDR == ADR_QUAD_DATA;
   endsequence
   sequence reg_read_s;
      CE && !RD_PIN && RD_REG && ADDR == ADR_SEVEN_DATA;
   endsequence
   sequence dir_write_s;
      CE && WR && ADDR == ADR_QUAD_DIR;
   endsequence

   quad_dir_write_a: assert property (dir_write_s |=>
      quad_dir == ($past(WDATA) & QUAD_MASK))
      else $error("quad direction not stored");
   quad_pin_read_a: assert property (pin_read_s |=>
      RDATA == ($past(quad_in) & QUAD_MASK))
      else $error("pin read wrong");
   seven_reg_read_a: assert property (reg_read_s |=>
      RDATA == $past(seven_data))
      else $error("register read wrong");
   alt_reset_a: assert property (@(posedge SYS_CLK) disable iff (1'b0)
      !RSTN |=> quad_alt == REG_RESET && second_alt == REG_RESET)
      else $error("select registers not cleared");
   buzzer_route_a: assert property (
      CE && quad_alt[QUAD_BUZ_BIT] && !quad_od[QUAD_BUZ_BIT]
      |=> QUAD_PIN_OE[QUAD_BUZ_BIT]
      && QUAD_PIN_O[QUAD_BUZ_BIT] == $past(BUZZER_WAVE))
      else $error("buzzer not routed");
   pwm_route_a: assert property (
      CE && second_alt[PWM_SEL_BIT] && !single_od
      |=> SINGLE_PIN_OE && SINGLE_PIN_O == $past(PWM_TIMER_WAVE))
      else $error("pwm wave not routed");
   irq_two_a: assert property (
      CE && second_alt[IRQ2_SEL_BIT]
      |=> EXT_IRQ[2] == $past(seven_in[SEVEN_IRQ2_BIT]))
      else $error("irq2 level not passed");
   osc_hold_a: assert property (
      $past(CE) && !MAIN_OSC_IO_OPT && $past(!MAIN_OSC_IO_OPT)
      |-> (SEVEN_PIN_OE & SEVEN_MAIN_OSC) == REG_RESET)
      else $error("main osc pin driven");
   reset_pin_a: assert property (
      !SEVEN_PIN_OE[SEVEN_RST_BIT])
      else $error("reset pin driven");
   subclk_free_a: assert property (
      CE && WR && ADDR == ADR_CTRL && WDATA[SUBCLK_DIS_BIT]
      |=> SUBCLK_DISABLE)
      else $error("sub clock not disabled");
endmodule

/* verif/pmgp_pin_model.sv */
// pin-side model: resolves each port wire from drive, pull-up and outside
`timescale 1ns/1ns
module pmgp_pin_model #(parameter int W = 8) (
   input wire logic [W-1:0] drv_o,
   input wire logic [W-1:0] drv_oe,
   input wire logic [W-1:0] drv_pu,
   input wire logic [W-1:0] outside,
   output logic [W-1:0] level
);
   // a released wire shows the pull-up or the outside level, never the last driven one,
   // so a design that forgets to drive cannot pass by luck
   always_comb begin
      for (int i = 0; i < W; i++) begin
         level[i] = drv_oe[i] ? drv_o[i] : (drv_pu[i] | outside[i]);
      end
   end
endmodule

/* verif/tb.sv */
// self-checking bench for the multiplexed gpio ports
`timescale 1ns/1ns
module tb;
   import pmgp_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr_s = 1'b0;
   logic rd_r = 1'b0, rd_p = 1'b0, mopt = 1'b0, ropt = 1'b0;
   logic buz = 1'b0, pwm = 1'b0, sx = 1'b0;
   logic [7:0] adr = 8'h00, wd = 8'h00, qx = 8'h00, vx = 8'h00;
   logic [5:0] xx = 6'h00;
   logic [7:0] rdat, qo, qoe, qpu, qi, vo, voe, vpu, vi, v, x;
   logic [7:0] d, r, o, u, h, m, pm, eoe, lvl;
   logic [5:0] xo, xoe, xpu, xi;
   logic so, soe, spu, si, tev, rlev, sdis;
   logic [3:0] irq;
   logic [31:0] st = 32'he102_b82b;
   logic [7:0] go[4], ge[4], gu[4], gx[4];
   logic [7:0] ad[4] = '{ADR_QUAD_DATA, ADR_SINGLE_DATA, ADR_SIX_DATA,
      ADR_SEVEN_DATA};
   logic [7:0] ar[4] = '{ADR_QUAD_DIR, ADR_SINGLE_DIR, ADR_SIX_DIR,
      ADR_SEVEN_DIR};
   logic [7:0] au[4] = '{ADR_QUAD_PU, ADR_SINGLE_PU, ADR_SIX_PU,
      ADR_SEVEN_PU};
   logic [7:0] ao[4] = '{ADR_QUAD_OD, ADR_SINGLE_OD, ADR_SIX_OD,
      ADR_SEVEN_OD};
   logic [7:0] km[4] = '{8'hD2, 8'h01, 8'h3F, 8'h7E};
   int err_total = 0;
   int checks_done = 0;

   // port views gathered per index so one loop serves all four ports
   always_comb begin
      go = '{qo, {7'h00, so}, {2'h0, xo}, vo};
      ge = '{qoe, {7'h00, soe}, {2'h0, xoe}, voe};
      gu = '{qpu, {7'h00, spu}, {2'h0, xpu}, vpu};
      gx = '{qx, {7'h00, sx}, {2'h0, xx}, vx};
   end

   // clock at 10 MHz
   always #50 clk = ~clk;

   pmgp_top dut_u (.SYS_CLK(clk), .RSTN(rstn), .CE(ce), .ADDR(adr),
      .WDATA(wd), .WR(wr_s), .RD_REG(rd_r), .RD_PIN(rd_p), .RDATA(rdat),
      .QUAD_PIN_I(qi), .QUAD_PIN_O(qo), .QUAD_PIN_OE(qoe),
      .QUAD_PIN_PU(qpu), .SINGLE_PIN_I(si), .SINGLE_PIN_O(so),
      .SINGLE_PIN_OE(soe), .SINGLE_PIN_PU(spu), .SIX_PIN_I(xi),
      .SIX_PIN_O(xo), .SIX_PIN_OE(xoe), .SIX_PIN_PU(xpu),
      .SEVEN_PIN_I(vi), .SEVEN_PIN_O(vo), .SEVEN_PIN_OE(voe),
      .SEVEN_PIN_PU(vpu), .MAIN_OSC_IO_OPT(mopt), .RESET_PIN_IO_OPT(ropt),
      .BUZZER_WAVE(buz), .PWM_TIMER_WAVE(pwm), .TIMER0_EVENT(tev),
      .EXT_IRQ(irq), .RESET_PIN_LEVEL(rlev), .SUBCLK_DISABLE(sdis));
   pmgp_pin_model #(.W(8)) quad_m (.drv_o(qo), .drv_oe(qoe),
      .drv_pu(qpu), .outside(qx), .level(qi));
   pmgp_pin_model #(.W(1)) single_m (.drv_o(so), .drv_oe(soe),
      .drv_pu(spu), .outside(sx), .level(si));
   pmgp_pin_model #(.W(6)) six_m (.drv_o(xo), .drv_oe(xoe),
      .drv_pu(xpu), .outside(xx), .level(xi));
   pmgp_pin_model #(.W(8)) seven_m (.drv_o(vo), .drv_oe(voe),
      .drv_pu(vpu), .outside(vx), .level(vi));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] xs();
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      return st[7:0];
   endfunction

   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask

   // whole-byte write; strobe drops a cycle later so it never re-fires
   task wr(input logic [7:0] a, input logic [7:0] dv);
      @(negedge clk);
      adr = a;
      wd = dv;
      wr_s = 1'b1;
      @(negedge clk);
      wr_s = 1'b0;
   endtask

   task rd(input logic [7:0] a, input logic pin, output logic [7:0] rv);
      @(negedge clk);
      adr = a;
      rd_r = ~pin;
      rd_p = pin;
      @(negedge clk);
      rd_r = 1'b0;
      rd_p = 1'b0;
      rv = rdat;
   endtask

   task end_sim;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // hang guard, far beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      end_sim();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      chk(voe, 8'h00);
      chk({2'h0, xoe}, 8'h00);
      chk({7'h00, sdis}, 8'h00);
      rd(ADR_SEVEN_DATA, 1'b0, v);
      chk(v, 8'h00);
      rd(ADR_CTRL, 1'b0, v);
      chk(v, 8'h00);
      rd(8'hB0, 1'b0, v);
      chk(v, 8'h00);
      // random data, direction, pull-up and open drain on every port
      for (int p = 0; p < 4; p++) begin
         repeat (4) begin
            {d, r, o, u, qx, vx, x} = {xs(), xs(), xs(), xs(), xs(), xs(),
               xs()};
            mopt = x[0];
            ropt = x[1];
            sx = x[3];
            xx = x[7:2];
            wr(ADR_CTRL, {x[2], 7'h00});
            wr(ao[p], o);
            wr(au[p], u);
            wr(ad[p], d);
            wr(ar[p], r);
            repeat (4) @(negedge clk);
            h = (mopt ? 8'h00 : SEVEN_MAIN_OSC) |
               (x[2] ? 8'h00 : SEVEN_SUB_OSC);
            m = (p == 3) ? km[p] & ~h : km[p];
            pm = (p == 3) ? 8'hFE & ~h & ~(ropt ? 8'h00 : SEVEN_RST_PIN)
               : km[p];
            eoe = r & m & ~(o & d);
            lvl = (eoe & d & ~o) | (~eoe & ((u & pm) | gx[p]));
            chk({7'h00, sdis}, {7'h00, x[2]});
            chk(ge[p], eoe);
            chk(go[p] & ge[p], d & r & ~o & m);
            chk(gu[p], u & pm);
            rd(ad[p], 1'b0, v);
            chk(v, d & km[p]);
            rd(ad[p], 1'b1, v);
            chk(v & m, lvl & m);
         end
      end
      // alternate functions with every quad and seven-bit pin an input, no pull-up
      wr(ADR_QUAD_DIR, 8'h00);
      wr(ADR_QUAD_OD, 8'h00);
      wr(ADR_QUAD_PU, 8'h00);
      wr(ADR_SEVEN_DIR, 8'h00);
      wr(ADR_SEVEN_PU, 8'h00);
      wr(ADR_SINGLE_OD, 8'h00);
      wr(ADR_QUAD_ALT, 8'hD2);
      wr(ADR_SECOND_ALT, 8'h07);
      repeat (6) begin
         {x, qx, vx} = {xs(), xs(), xs()};
         buz = x[0];
         pwm = x[1];
         repeat (4) @(negedge clk);
         chk({7'h00, qoe[4]}, 8'h01);
         chk({7'h00, qo[4]}, {7'h00, buz});
         chk({7'h00, soe}, 8'h01);
         chk({7'h00, so}, {7'h00, pwm});
         chk({7'h00, tev}, {7'h00, qx[1]});
         chk({4'h0, irq}, {4'h0, vx[4], vx[1], qx[7], qx[6]});
         chk({7'h00, rlev}, {7'h00, vx[7]});
      end
      // deselected inputs give the peripherals nothing
      wr(ADR_QUAD_ALT, 8'h00);
      wr(ADR_SECOND_ALT, 8'h00);
      repeat (4) @(negedge clk);
      chk({3'h0, irq, tev}, 8'h00);
      // a write while the clock enable is low is ignored
      wr(ADR_SIX_DATA, 8'h15);
      ce = 1'b0;
      wr(ADR_SIX_DATA, 8'h2A);
      ce = 1'b1;
      rd(ADR_SIX_DATA, 1'b0, v);
      chk(v, 8'h15);
      end_sim();
   end
endmodule
